// ---- csb_pkg.sv ----
/*
  shared constants and carrier types for the cpu standby, break and opcode core.
  assumes a byte-wide program memory bus with combinational read data.
*/
package csb_pkg;

  // opcodes decoded by the core; trap, return, wait, stop and carry values are plain defaults
  localparam logic [7:0] OP_STACK_ADD_IMM = 8'ha7;
  localparam logic [7:0] OP_INDEX_ADD_IMM = 8'haf;
  localparam logic [7:0] OP_BR_CARRY_CLR  = 8'h24;
  localparam logic [7:0] OP_BR_CARRY_SET  = 8'h25;
  localparam logic [7:0] OP_SW_TRAP       = 8'h83;
  localparam logic [7:0] OP_RET_TRAP      = 8'h80;
  localparam logic [7:0] OP_WAIT          = 8'h8f;
  localparam logic [7:0] OP_STOP          = 8'h8e;
  localparam logic [7:0] OP_SET_CARRY     = 8'h99;
  localparam logic [7:0] OP_CLR_CARRY     = 8'h98;

  // vector addresses (high byte at the even address)
  localparam logic [15:0] VEC_BREAK   = 16'hfffc;
  localparam logic [15:0] VEC_MONITOR = 16'hfefc;
  localparam logic [15:0] VEC_IRQ     = 16'hfffa;
  localparam logic [15:0] VEC_RESET   = 16'hfffe;

  // reset values
  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam logic [15:0] HX_RESET = 16'h0000;

  // oscillator stabilisation after stop
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          OSC_STAB_NS   = 16384;
  localparam int          OSC_CYC_INT   = OSC_STAB_NS / CLK_PERIOD_NS;
  localparam logic [12:0] OSC_CYC       = 13'(OSC_CYC_INT);

  typedef enum logic [6:0] {
    S_FETCH = 7'b0000001,
    S_OPER  = 7'b0000010,
    S_EXEC  = 7'b0000100,
    S_VHI   = 7'b0001000,
    S_VLO   = 7'b0010000,
    S_STBY  = 7'b0100000,
    S_OSC   = 7'b1000000
  } csb_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
  } csb_mem_req_t;

  typedef struct packed {
    logic [15:0] program_counter;
    logic [15:0] stack_pointer;
    logic [15:0] index_pair;
    logic        imask;
    logic        carry;
    logic        in_break;
    logic        stop_mode;
  } csb_regs_t;

endpackage

// ---- csb_sx_add.sv ----
/*
  16-bit adder of a sign-extended byte.
  assumes nothing beyond its operands; purely combinational.
*/
`timescale 1ns/1ns
module csb_sx_add (
  input  wire logic [15:0] i_base,  // 16-bit operand
  input  wire logic [7:0]  i_ofs,   // signed byte
  output logic      [15:0] o_sum    // base plus extended byte
);
  assign o_sum = i_base + {{8{i_ofs[7]}}, i_ofs};
endmodule

// ---- csb_core.sv ----
/*
  cpu control core: wait/stop standby, break entry and exit, and decode of the
  immediate stack/index adds and the carry branches.
  assumes program memory answers combinationally on i_rdata for o_mem.addr,
  and that the break module holds i_brk_req until the break routine withdraws it.
  // Notes on behaviour
  // - the wait instruction clears the interrupt mask and then stops the cpu clock.
  // - leaving wait by interrupt keeps the mask clear, leaving it by reset sets it.
  // - the stop instruction clears the interrupt mask and stops the cpu clock.
  // - leaving stop by external interrupt keeps the mask clear, leaving it by reset sets it.
  // - in either standby mode the cpu clock stays off until the mode ends.
  // - after stop ends the cpu clock waits for the oscillator stabilisation delay.
  // - a break request forces the software trap opcode into the instruction register.
  // - break entry loads the program counter from fffc/fffd, or fefc/fefd in monitor mode.
  // - a break waits until the instruction in progress has finished.
  // - a break match on the last cycle of an instruction starts the break at once.
  // - a return from trap ends the break only once the break request is withdrawn.
  // - opcode a7 adds its sign-extended byte to the stack pointer in 2 cycles.
  // - opcode af adds its sign-extended byte to the index pair in 2 cycles.
  // - opcode 24 branches on carry clear in 3 cycles and leaves the flags alone.
  // - opcode 25 sets the program counter to pc plus 2 plus offset on carry set in 3 cycles.
  // - while the mask is set maskable requests are ignored; clearing it lets them through.
*/
`timescale 1ns/1ns
module csb_core (
  input  wire logic                  i_mclk,       // cpu clock, 250 MHz
  input  wire logic                  i_resetn,     // async reset, active low
  input  wire logic                  i_ce,         // clock enable, freezes state when low
  input  wire logic [7:0]            i_rdata,      // program memory read data
  input  wire logic                  i_brk_req,    // break module request
  input  wire logic                  i_monitor,    // monitor mode active
  input  wire logic                  i_irq,        // maskable internal interrupt request
  input  wire logic                  i_ext_irq,    // maskable external interrupt request
  output csb_pkg::csb_mem_req_t      o_mem,        // memory address and read strobe
  output csb_pkg::csb_regs_t         o_regs,       // architectural state
  output logic [7:0]                 o_ir,         // instruction register
  output logic                       o_cpu_clk_en, // cpu clock gate, high while running
  output logic                       o_standby     // in wait or stop or stabilising
);
  import csb_pkg::*;

  logic [1:0]   rst_sync;
  logic         rst_n;
  csb_state_t   st;
  csb_state_t   next_st;
  csb_regs_t    r;
  csb_regs_t    next_r;
  logic [7:0]   ir;
  logic [7:0]   next_ir;
  logic [7:0]   opnd;
  logic [7:0]   next_opnd;
  logic [15:0]  vec;
  logic [15:0]  next_vec;
  logic [12:0]  cnt;
  logic [12:0]  next_cnt;
  logic         brk_pend;
  logic         next_brk_pend;
  csb_mem_req_t mem;
  csb_mem_req_t next_mem;
  logic [15:0]  sp_sum;
  logic [15:0]  hx_sum;
  logic [15:0]  br_sum;
  logic         go_brk;
  logic         go_irq;
  logic         take_op;
  logic         wake;

  // reset release through two flops
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  csb_sx_add u_sp_add (
    .i_base (r.stack_pointer),
    .i_ofs  (i_rdata),
    .o_sum  (sp_sum)
  );
  csb_sx_add u_hx_add (
    .i_base (r.index_pair),
    .i_ofs  (i_rdata),
    .o_sum  (hx_sum)
  );
  csb_sx_add u_br_add (
    .i_base (r.program_counter),
    .i_ofs  (opnd),
    .o_sum  (br_sum)
  );

  // break only at an instruction boundary; a request seen mid-instruction is held
  assign go_brk  = (st == S_FETCH) && (brk_pend || i_brk_req) && !r.in_break;
  assign go_irq  = (st == S_FETCH) && (i_irq || i_ext_irq) && !r.imask;
  assign take_op = (st == S_FETCH) && !go_brk && !go_irq;
  // stop only wakes on external requests
  assign wake    = i_ext_irq || (!r.stop_mode && i_irq);

  always_comb begin
    next_st       = st;
    next_r        = r;
    next_ir       = ir;
    next_opnd     = opnd;
    next_vec      = vec;
    next_cnt      = cnt;
    next_brk_pend = (brk_pend || i_brk_req) && !r.in_break;
    unique case (st)
      S_FETCH: begin
        if (go_brk) begin
          next_ir         = OP_SW_TRAP;
          next_vec        = i_monitor ? VEC_MONITOR : VEC_BREAK;
          next_r.in_break = 1'b1;
          next_brk_pend   = 1'b0;
          next_st         = S_VHI;
        end else if (go_irq) begin
          next_r.imask = 1'b1;
          next_vec     = VEC_IRQ;
          next_st      = S_VHI;
        end else begin
          next_ir                = i_rdata;
          next_r.program_counter = r.program_counter + 16'h1;
          unique case (i_rdata)
            OP_WAIT: begin
              next_r.imask     = 1'b0;
              next_r.stop_mode = 1'b0;
              next_st          = S_STBY;
            end
            OP_STOP: begin
              next_r.imask     = 1'b0;
              next_r.stop_mode = 1'b1;
              next_st          = S_STBY;
            end
            OP_STACK_ADD_IMM, OP_INDEX_ADD_IMM, OP_BR_CARRY_CLR, OP_BR_CARRY_SET: begin
              next_st = S_OPER;
            end
            OP_RET_TRAP: begin
              if (r.in_break && !i_brk_req) begin
                next_r.in_break = 1'b0;
              end
            end
            OP_SET_CARRY: begin
              next_r.carry = 1'b1;
            end
            OP_CLR_CARRY: begin
              next_r.carry = 1'b0;
            end
            default: begin
            end
          endcase
        end
      end
      S_OPER: begin
        next_r.program_counter = r.program_counter + 16'h1;
        if (ir == OP_STACK_ADD_IMM) begin
          next_r.stack_pointer = sp_sum;
          next_st              = S_FETCH;
        end else if (ir == OP_INDEX_ADD_IMM) begin
          next_r.index_pair = hx_sum;
          next_st           = S_FETCH;
        end else begin
          next_opnd = i_rdata;
          next_st   = S_EXEC;
        end
      end
      S_EXEC: begin
        // pc already points past the offset byte; flags untouched
        if ((ir == OP_BR_CARRY_SET) == r.carry) begin
          next_r.program_counter = br_sum;
        end
        next_st = S_FETCH;
      end
      S_VHI: begin
        next_opnd = i_rdata;
        next_st   = S_VLO;
      end
      S_VLO: begin
        next_r.program_counter = {opnd, i_rdata};
        next_st                = S_FETCH;
      end
      S_STBY: begin
        next_cnt = 13'h0;
        if (wake) begin
          next_st = r.stop_mode ? S_OSC : S_FETCH;
        end
      end
      S_OSC: begin
        next_cnt = cnt + 13'h1;
        if (cnt == OSC_CYC - 13'h1) begin
          next_st = S_FETCH;
        end
      end
      default: begin
        next_st = S_FETCH;
      end
    endcase
    next_mem.rd   = (next_st == S_FETCH) || (next_st == S_OPER) || (next_st == S_VHI) || (next_st == S_VLO);
    next_mem.addr = (next_st == S_VHI) ? next_vec :
                    (next_st == S_VLO) ? vec + 16'h1 : next_r.program_counter;
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      st       <= S_VHI;
      r        <= '{program_counter: 16'h0, stack_pointer: SP_RESET, index_pair: HX_RESET,
                    imask: 1'b1, carry: 1'b0, in_break: 1'b0, stop_mode: 1'b0};
      ir       <= 8'h0;
      opnd     <= 8'h0;
      vec      <= VEC_RESET;
      cnt      <= 13'h0;
      brk_pend <= 1'b0;
      mem      <= '{addr: VEC_RESET, rd: 1'b1};
    end else if (i_ce) begin
      st       <= next_st;
      r        <= next_r;
      ir       <= next_ir;
      opnd     <= next_opnd;
      vec      <= next_vec;
      cnt      <= next_cnt;
      brk_pend <= next_brk_pend;
      mem      <= next_mem;
    end
  end

  assign o_mem        = mem;
  assign o_regs       = r;
  assign o_ir         = ir;
  assign o_cpu_clk_en = !((st == S_STBY) || (st == S_OSC));
  assign o_standby    = (st == S_STBY) || (st == S_OSC);

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!rst_n);

  a_wait_mask_clr: assert property (take_op && i_ce && i_rdata == OP_WAIT
    |=> !r.imask && !o_cpu_clk_en && !r.stop_mode)
    else $error("wait did not clear mask and gate clock");
  a_stop_mask_clr: assert property (take_op && i_ce && i_rdata == OP_STOP
    |=> !r.imask && !o_cpu_clk_en && r.stop_mode)
    else $error("stop did not clear mask and gate clock");
  a_wait_exit_irq: assert property (st == S_STBY && !r.stop_mode && i_irq && i_ce
    |=> st == S_FETCH && !r.imask && o_mem.rd)
    else $error("wait exit lost mask state or fetch");
  a_stop_ignores_irq: assert property (st == S_STBY && r.stop_mode && !i_ext_irq
    |=> st == S_STBY && !o_cpu_clk_en)
    else $error("stop left without external request");
  a_stop_exit_ext: assert property (st == S_STBY && r.stop_mode && i_ext_irq && i_ce
    |=> st == S_OSC && !r.imask && cnt == 13'h0 && !o_cpu_clk_en)
    else $error("stop exit by external request lost mask state");
  // a break request while the break routine runs must never re-enter the trap
  a_brk_no_reenter: assert property (r.in_break |-> !go_brk)
    else $error("break re-entered while in break");
  a_osc_delay_end: assert property (st == S_OSC && cnt == OSC_CYC - 13'h1 && i_ce
    |=> st == S_FETCH && o_cpu_clk_en)
    else $error("clock did not restart after stabilisation");
  a_osc_not_early: assert property (st == S_OSC |-> cnt < OSC_CYC && !o_cpu_clk_en)
    else $error("clock restarted before stabilisation");
  a_brk_trap_vec: assert property (go_brk && i_ce
    |=> o_ir == OP_SW_TRAP && o_mem.addr == ($past(i_monitor) ? VEC_MONITOR : VEC_BREAK))
    else $error("break entry did not force trap or vector");
  a_brk_vec_low: assert property (go_brk && i_ce ##1 i_ce
    |=> o_mem.addr == ($past(i_monitor, 2) ? VEC_MONITOR : VEC_BREAK) + 16'h1)
    else $error("break vector low byte address wrong");
  a_brk_deferred: assert property (i_brk_req && st == S_OPER && !r.in_break && i_ce
    |=> !(st inside {S_VHI, S_VLO}) || o_ir != OP_SW_TRAP)
    else $error("break taken mid instruction");
  a_brk_last_cyc: assert property (i_brk_req && st == S_OPER && !r.in_break && i_ce
    && (ir == OP_STACK_ADD_IMM || ir == OP_INDEX_ADD_IMM) |=> go_brk)
    else $error("break on last cycle not taken at once");
  a_rti_held: assert property (take_op && i_ce && i_rdata == OP_RET_TRAP && r.in_break && i_brk_req
    |=> r.in_break)
    else $error("break ended while request held");
  a_rti_ends: assert property (take_op && i_ce && i_rdata == OP_RET_TRAP && r.in_break && !i_brk_req
    |=> !r.in_break)
    else $error("break not ended by return");
  a_stack_add: assert property (take_op && i_ce && i_rdata == OP_STACK_ADD_IMM ##1 i_ce
    |=> st == S_FETCH && r.stack_pointer == $past(r.stack_pointer) + {{8{$past(i_rdata[7])}}, $past(i_rdata)})
    else $error("stack add wrong sum or length");
  a_index_add: assert property (take_op && i_ce && i_rdata == OP_INDEX_ADD_IMM ##1 i_ce
    |=> st == S_FETCH && r.index_pair == $past(r.index_pair) + {{8{$past(i_rdata[7])}}, $past(i_rdata)})
    else $error("index add wrong sum or length");
  a_branch_len: assert property (take_op && i_ce && (i_rdata == OP_BR_CARRY_CLR || i_rdata == OP_BR_CARRY_SET)
    ##1 i_ce[*2] |=> st == S_FETCH && $stable(r.carry))
    else $error("carry branch length or flags wrong");
  a_bcs_target: assert property (st == S_EXEC && ir == OP_BR_CARRY_SET && r.carry && i_ce
    |=> r.program_counter == $past(r.program_counter) + {{8{$past(opnd[7])}}, $past(opnd)})
    else $error("branch on carry set target wrong");
  a_mask_blocks: assert property (r.imask |-> !go_irq)
    else $error("maskable request taken while masked");

  c_wait_wake: cover property (st == S_STBY && !r.stop_mode ##1 st == S_FETCH);
  c_stop_wake: cover property (st == S_OSC ##1 st == S_FETCH);
  c_break_rti: cover property (go_brk ##[1:200] (take_op && i_rdata == OP_RET_TRAP && !i_brk_req));
  c_bcs_taken: cover property (st == S_EXEC && ir == OP_BR_CARRY_SET && r.carry);
  c_brk_latched: cover property (st == S_OPER && i_brk_req && !r.in_break ##1 go_brk);
endmodule

// ---- csb_mem_model.sv ----
/*
  program memory partner for the cpu control core: byte array, combinational read.
  assumes the bench fills the array by hierarchical writes after time zero.
*/
`timescale 1ns/1ns
module csb_mem_model (
  input  wire csb_pkg::csb_mem_req_t i_mem,   // address and read strobe from the core
  input  wire logic                  i_mclk,  // cpu clock
  output logic [7:0]                 o_rdata  // read data, valid in the same cycle
);
  import csb_pkg::*;
  logic [7:0] mem [0:65535];
  logic [7:0] last;

  initial begin
    foreach (mem[k]) mem[k] = 8'h00;
    last = 8'h00;
  end

  always @(posedge i_mclk) begin
    if (i_mem.rd) last <= o_rdata;
  end

  // without a read strobe show the inverse of the last byte so stale data never passes
  assign o_rdata = i_mem.rd ? mem[i_mem.addr] : ~last;
endmodule

// ---- tb_top.sv ----
/*
  self-checking bench for the cpu standby, break and opcode core.
  assumes csb_mem_model answers reads; the bench plays the break module and interrupt sources.
*/
`timescale 1ns/1ns
`define CHK(nm, got, exp) begin checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module tb_top;
  import csb_pkg::*;
  typedef struct packed {
    logic        en;
    logic        rd;
    logic [15:0] addr;
  } csb_note_t;
  logic         i_mclk    = 1'b0;
  logic         i_resetn  = 1'b0;
  logic         i_ce      = 1'b1;
  logic         i_brk_req = 1'b0;
  logic         i_monitor = 1'b0;
  logic         i_irq     = 1'b1;
  logic         i_ext_irq = 1'b0;
  logic [7:0]   i_rdata;
  csb_mem_req_t o_mem;
  csb_regs_t    o_regs;
  logic [7:0]   o_ir;
  logic         o_cpu_clk_en;
  logic         o_standby;
  csb_note_t    notes[$];
  csb_note_t    n;
  logic         sync      = 1'b1;
  logic         ce_rand   = 1'b0;
  logic [7:0]   ii1;
  logic [7:0]   ii2;
  logic [15:0]  vec;
  int           bad_count = 0;
  int           checked   = 0;
  logic [23:0]  img[$]    = '{24'hfffe10, 24'hffff00, 24'hfffc20, 24'hfffd00, 24'hfefc20, 24'hfefd00,
                              24'hfffa40, 24'hfffb00, 24'h1000a7, 24'h200080, 24'h200180, 24'h2002af,
                              24'h200499, 24'h200525, 24'h200610, 24'h201724, 24'h201855, 24'h201998,
                              24'h201a24, 24'h201bf0, 24'h200c8f, 24'h40008e};

  always #2 i_mclk = ~i_mclk;

  always @(posedge i_mclk) begin
    i_ce <= ce_rand ? ($urandom % 4 != 0) : 1'b1;
  end

  csb_mem_model u_mem (.i_mem(o_mem), .i_mclk(i_mclk), .o_rdata(i_rdata));

  csb_core DUT (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(i_ce), .i_rdata(i_rdata), .i_brk_req(i_brk_req),
    .i_monitor(i_monitor), .i_irq(i_irq), .i_ext_irq(i_ext_irq), .o_mem(o_mem), .o_regs(o_regs),
    .o_ir(o_ir), .o_cpu_clk_en(o_cpu_clk_en), .o_standby(o_standby)
  );

  task automatic seq(input logic [15:0] a, input int cnt);
    for (int k = 0; k < cnt; k++) notes.push_back('{1'b1, 1'b1, a + 16'(k)});
  endtask

  task automatic idle(input logic en, input int cnt);
    repeat (cnt) notes.push_back('{en, 1'b0, 16'h0000});
  endtask

  task automatic wait_addr(input logic [15:0] a);
    int k;
    for (k = 0; k < 5000; k++) begin
      @(negedge i_mclk);
      if (i_resetn && i_ce && o_mem.rd === 1'b1 && o_mem.addr === a) break;
    end
    if (k == 5000) begin
      bad_count++;
      $display("Error fetch expected %h seen none", a);
    end
  endtask

  task stop_test;
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // every enabled cycle after the reset vector, while notes remain queued, is compared with the oldest note
  always @(negedge i_mclk) begin
    if (i_resetn && i_ce) begin
      if (sync) begin
        if (o_mem.rd === 1'b1 && o_mem.addr === 16'hffff) sync = 1'b0;
      end else if (notes.size() > 0) begin
        n = notes.pop_front();
        `CHK("clk_en", o_cpu_clk_en, n.en)
        `CHK("rd", o_mem.rd, n.rd)
        if (n.rd) `CHK("addr", o_mem.addr, n.addr)
      end
    end
  end

  initial begin
    repeat (20000) @(posedge i_mclk);
    bad_count++;
    $display("Error watchdog expected done seen timeout");
    stop_test;
  end

  initial begin
    void'($urandom(53380));
    ii1 = 8'($urandom);
    ii2 = 8'($urandom);
    vec = ($urandom % 2) ? VEC_MONITOR : VEC_BREAK;
    @(posedge i_mclk);
    foreach (img[k]) u_mem.mem[img[k][23:8]] = img[k][7:0];
    u_mem.mem[16'h1001] = ii1;
    u_mem.mem[16'h2003] = ii2;
    i_monitor <= (vec == VEC_MONITOR);
    repeat (3) @(posedge i_mclk);
    i_resetn <= 1'b1;
    seq(16'h1000, 3);
    seq(vec, 2);
    seq(16'h2000, 7);
    idle(1'b1, 1);
    seq(16'h2017, 2);
    idle(1'b1, 1);
    seq(16'h2019, 3);
    idle(1'b1, 1);
    seq(16'h200c, 1);
    wait_addr(16'h1000);
    @(posedge i_mclk);
    i_brk_req <= 1'b1;
    wait_addr(vec);
    `CHK("ir", o_ir, OP_SW_TRAP)
    `CHK("sp", o_regs.stack_pointer, SP_RESET + {{8{ii1[7]}}, ii1})
    wait_addr(16'h2000);
    @(posedge i_mclk);
    i_brk_req <= 1'b0;
    wait_addr(16'h2001);
    `CHK("in_break", o_regs.in_break, 1'b1)
    wait_addr(16'h2002);
    `CHK("in_break", o_regs.in_break, 1'b0)
    ce_rand = 1'b1;
    wait_addr(16'h2004);
    `CHK("hx", o_regs.index_pair, HX_RESET + {{8{ii2[7]}}, ii2})
    wait_addr(16'h2019);
    `CHK("carry", o_regs.carry, 1'b1)
    wait_addr(16'h200c);
    ce_rand = 1'b0;
    @(posedge i_mclk);
    i_irq <= 1'b0;
    repeat (4) @(posedge i_mclk);
    @(negedge i_mclk);
    `CHK("imask", o_regs.imask, 1'b0)
    `CHK("standby", o_standby, 1'b1)
    @(posedge i_mclk);
    i_irq <= 1'b1;
    idle(1'b0, 1);
    seq(16'h200d, 1);
    seq(VEC_IRQ, 2);
    seq(16'h4000, 1);
    wait_addr(16'h200d);
    `CHK("imask", o_regs.imask, 1'b0)
    wait_addr(16'h4000);
    `CHK("imask", o_regs.imask, 1'b1)
    repeat (12) @(posedge i_mclk);
    @(negedge i_mclk);
    `CHK("imask", o_regs.imask, 1'b0)
    `CHK("clk_en", o_cpu_clk_en, 1'b0)
    @(posedge i_mclk);
    i_ext_irq <= 1'b1;
    idle(1'b0, OSC_CYC_INT + 1);
    seq(16'h4001, 1);
    seq(VEC_IRQ, 2);
    seq(16'h4000, 1);
    @(posedge i_mclk);
    i_ext_irq <= 1'b0;
    wait_addr(16'h4001);
    `CHK("imask", o_regs.imask, 1'b0)
    wait_addr(16'h4000);
    repeat (3) @(posedge i_mclk);
    sync = 1'b1;
    seq(16'h1000, 3);
    i_resetn <= 1'b0;
    @(negedge i_mclk);
    `CHK("imask", o_regs.imask, 1'b1)
    `CHK("clk_en", o_cpu_clk_en, 1'b1)
    repeat (4) @(posedge i_mclk);
    i_resetn <= 1'b1;
    wait_addr(16'h1002);
    @(negedge i_mclk);
    `CHK("notes", notes.size(), 0)
    stop_test;
  end
endmodule
